// *** src/ipd_pkg.sv ***
// Shared constants and types for the indexed postbyte decoder.
// Assumes a single processor clock; every consumer imports the whole package.
package ipd_pkg;

  // Postbyte field positions.
  localparam int unsigned PB_MODE_BIT = 7;
  localparam int unsigned PB_SEL_HI   = 6;
  localparam int unsigned PB_SEL_LO   = 5;
  localparam int unsigned PB_IND_BIT  = 4;
  localparam int unsigned PB_OFF5_HI  = 4;
  localparam int unsigned PB_LOW_HI   = 3;

  // Base select field codes.
  localparam logic [1:0] SEL_INDEX_ONE  = 2'h0;
  localparam logic [1:0] SEL_INDEX_TWO  = 2'h1;
  localparam logic [1:0] SEL_SECOND_STK = 2'h2;
  localparam logic [1:0] SEL_CALL_FRAME = 2'h3;

  // Low nibble form codes when the mode bit is set.
  localparam logic [3:0] LN_INC1      = 4'h0;
  localparam logic [3:0] LN_INC2      = 4'h1;
  localparam logic [3:0] LN_DEC1      = 4'h2;
  localparam logic [3:0] LN_DEC2      = 4'h3;
  localparam logic [3:0] LN_ZERO      = 4'h4;
  localparam logic [3:0] LN_ACC_LOW   = 4'h5;
  localparam logic [3:0] LN_ACC_HIGH  = 4'h6;
  localparam logic [3:0] LN_OFF8      = 4'h8;
  localparam logic [3:0] LN_OFF16     = 4'h9;
  localparam logic [3:0] LN_ACC_PAIR  = 4'hB;
  localparam logic [3:0] LN_PCREL8    = 4'hC;
  localparam logic [3:0] LN_PCREL16   = 4'hD;
  localparam logic [3:0] LN_ABS       = 4'hF;
  localparam logic [7:0] ABS_POSTBYTE = 8'h9F;

  // Extra cycle costs of the direct forms and of absolute indirect; indirection adds IND_EXTRA to all but the absolute form.
  localparam logic [3:0] CYC_NONE   = 4'h0;
  localparam logic [3:0] CYC_OFF5   = 4'h1;
  localparam logic [3:0] CYC_ZERO   = 4'h0;
  localparam logic [3:0] CYC_ACC8   = 4'h1;
  localparam logic [3:0] CYC_OFF8   = 4'h1;
  localparam logic [3:0] CYC_OFF16  = 4'h4;
  localparam logic [3:0] CYC_PAIR   = 4'h4;
  localparam logic [3:0] CYC_STEP1  = 4'h2;
  localparam logic [3:0] CYC_STEP2  = 4'h3;
  localparam logic [3:0] CYC_PCR8   = 4'h1;
  localparam logic [3:0] CYC_PCR16  = 4'h5;
  localparam logic [3:0] CYC_ABS    = 4'h5;
  localparam logic [3:0] IND_EXTRA  = 4'h3;

  // Extra byte counts.
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_ONE  = 2'h1;
  localparam logic [1:0] BYTES_TWO  = 2'h2;

  // Transfer/exchange register codes.
  localparam logic [3:0] XF_OCTET_PAIR = 4'h0;
  localparam logic [3:0] XF_INDEX_ONE  = 4'h1;
  localparam logic [3:0] XF_INDEX_TWO  = 4'h2;
  localparam logic [3:0] XF_SECOND_STK = 4'h3;
  localparam logic [3:0] XF_CALL_FRAME = 4'h4;
  localparam logic [3:0] XF_PROG_CNT   = 4'h5;
  localparam logic [3:0] XF_HIGH_OCTET = 4'h8;
  localparam logic [3:0] XF_LOW_OCTET  = 4'h9;
  localparam logic [3:0] XF_FLAG       = 4'hA;
  localparam logic [3:0] XF_PAGE_BASE  = 4'hB;

  typedef enum logic [2:0] {
    IPD_BASE_NONE, IPD_BASE_INDEX_ONE, IPD_BASE_INDEX_TWO,
    IPD_BASE_SECOND_STK, IPD_BASE_CALL_FRAME, IPD_BASE_PROG_CNT
  } ipd_base_t;

  typedef enum logic [2:0] {
    IPD_OFF_NONE, IPD_OFF_FIVE, IPD_OFF_EIGHT, IPD_OFF_SIXTEEN,
    IPD_OFF_ACC_HIGH, IPD_OFF_ACC_LOW, IPD_OFF_ACC_PAIR, IPD_OFF_ABSOLUTE
  } ipd_offset_t;

  typedef enum logic [2:0] {
    IPD_STEP_NONE, IPD_STEP_INC1, IPD_STEP_INC2, IPD_STEP_DEC1, IPD_STEP_DEC2
  } ipd_step_t;

  typedef enum logic [3:0] {
    IPD_REG_NONE, IPD_REG_OCTET_PAIR, IPD_REG_INDEX_ONE, IPD_REG_INDEX_TWO,
    IPD_REG_SECOND_STK, IPD_REG_CALL_FRAME, IPD_REG_PROG_CNT,
    IPD_REG_HIGH_OCTET, IPD_REG_LOW_OCTET, IPD_REG_FLAG, IPD_REG_PAGE_BASE
  } ipd_reg_t;

endpackage : ipd_pkg

// *** src/ipd_xfer_decode.sv ***
// Register field decoder for transfer and exchange postbytes.
// Assumes the sequencer presents one 4-bit field with a valid strobe.
`timescale 1ns/1ps
module ipd_xfer_decode
  import ipd_pkg::*;
(
  input  wire logic     clk_i,      // Processor clock.
  input  wire logic     rst_i,      // Asynchronous reset, active high.
  input  wire logic [3:0] code_i,   // Register field.
  input  wire logic     valid_i,    // Field valid strobe.
  output logic          valid_o,    // Decode valid, one cycle later.
  output ipd_reg_t      reg_o,      // Selected register.
  output logic          wide_o,     // Register is sixteen bits wide.
  output logic          illegal_o   // Field names no register.
);

  logic     valid_q, valid_d;
  ipd_reg_t reg_q, reg_d;
  logic     wide_q, wide_d;
  logic     ill_q, ill_d;

  // Decode the field; results hold between strobes so the datapath may sample late.
  always_comb begin
    valid_d = valid_i;
    reg_d   = reg_q;
    wide_d  = wide_q;
    ill_d   = ill_q;
    if (valid_i) begin
      wide_d = 1'b0;
      ill_d  = 1'b0;
      case (code_i)
        XF_OCTET_PAIR: begin reg_d = IPD_REG_OCTET_PAIR; wide_d = 1'b1; end
        XF_INDEX_ONE:  begin reg_d = IPD_REG_INDEX_ONE;  wide_d = 1'b1; end
        XF_INDEX_TWO:  begin reg_d = IPD_REG_INDEX_TWO;  wide_d = 1'b1; end
        XF_SECOND_STK: begin reg_d = IPD_REG_SECOND_STK; wide_d = 1'b1; end
        XF_CALL_FRAME: begin reg_d = IPD_REG_CALL_FRAME; wide_d = 1'b1; end
        XF_PROG_CNT:   begin reg_d = IPD_REG_PROG_CNT;   wide_d = 1'b1; end
        XF_HIGH_OCTET: reg_d = IPD_REG_HIGH_OCTET;
        XF_LOW_OCTET:  reg_d = IPD_REG_LOW_OCTET;
        XF_FLAG:       reg_d = IPD_REG_FLAG;
        XF_PAGE_BASE:  reg_d = IPD_REG_PAGE_BASE;
        default: begin
          reg_d = IPD_REG_NONE;
          ill_d = 1'b1;
        end
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      reg_q   <= IPD_REG_NONE;
      wide_q  <= 1'b0;
      ill_q   <= 1'b0;
    end else begin
      valid_q <= valid_d;
      reg_q   <= reg_d;
      wide_q  <= wide_d;
      ill_q   <= ill_d;
    end
  end

  assign valid_o   = valid_q;
  assign reg_o     = reg_q;
  assign wide_o    = wide_q;
  assign illegal_o = ill_q;

  // The flag register code must give a narrow register one cycle later.
  property p_xfer_flag;
    @(posedge clk_i) disable iff (rst_i)
    valid_i && code_i == XF_FLAG |=> valid_o && reg_o == IPD_REG_FLAG && !wide_o;
  endproperty
  a_xfer_flag: assert property (p_xfer_flag) else $error("flag code misdecoded");

endmodule : ipd_xfer_decode

// *** src/ipd_decoder.sv ***
// Indexed addressing postbyte decoder with transfer register field decode.
// Assumes the fetch sequencer strobes each fetched byte on the processor clock.
`timescale 1ns/1ps
module ipd_decoder
  import ipd_pkg::*;
(
  input  wire logic        clk_i,             // Processor clock, 100 MHz.
  input  wire logic        rst_i,             // Asynchronous reset, active high.
  input  wire logic [7:0]  postbyte_i,        // Fetched indexed postbyte.
  input  wire logic        postbyte_valid_i,  // Postbyte strobe.
  input  wire logic [3:0]  xfer_code_i,       // Transfer register field.
  input  wire logic        xfer_valid_i,      // Transfer field strobe.
  output logic             dec_valid_o,       // Decode result valid pulse.
  output ipd_base_t        base_o,            // Base register to add to.
  output ipd_offset_t      offset_kind_o,     // Offset source.
  output ipd_step_t        step_o,            // Auto step on the base.
  output logic             indirect_o,        // Address is fetched from memory.
  output logic             abs_indirect_o,    // Absolute indirect form.
  output logic [1:0]       extra_bytes_o,     // Offset bytes still to fetch.
  output logic [3:0]       extra_cycles_o,    // Extra cycles of this form.
  output logic [15:0]      short_offset_o,    // Sign-extended five-bit offset.
  output logic             illegal_o,         // Undefined postbyte.
  output logic             xfer_valid_o,      // Transfer decode valid.
  output ipd_reg_t         xfer_reg_o,        // Transfer register.
  output logic             xfer_wide_o,       // Transfer register is wide.
  output logic             xfer_illegal_o     // Transfer field undefined.
);

  // Maps the base select field onto a base register.
  function automatic ipd_base_t base_of(input logic [1:0] sel);
    ipd_base_t b;
    case (sel)
      SEL_INDEX_ONE:  b = IPD_BASE_INDEX_ONE;
      SEL_INDEX_TWO:  b = IPD_BASE_INDEX_TWO;
      SEL_SECOND_STK: b = IPD_BASE_SECOND_STK;
      SEL_CALL_FRAME: b = IPD_BASE_CALL_FRAME;
      default:        b = IPD_BASE_NONE;
    endcase
    return b;
  endfunction : base_of

  // Sign-extends the five-bit offset to the address width.
  function automatic logic [15:0] sext5(input logic [4:0] v);
    return {{11{v[4]}}, v};
  endfunction : sext5

  logic              valid_q, valid_d;
  ipd_base_t         base_q, base_d;
  ipd_offset_t       kind_q, kind_d;
  ipd_step_t         step_q, step_d;
  logic              ind_q, ind_d;
  logic              abs_q, abs_d;
  logic [1:0]        bytes_q, bytes_d;
  logic [3:0]        cyc_q, cyc_d;
  logic [15:0]       off_q, off_d;
  logic              ill_q, ill_d;

  logic [3:0]        low_nib;
  logic              ind_bit;

  assign low_nib = postbyte_i[PB_LOW_HI:0];
  assign ind_bit = postbyte_i[PB_IND_BIT];

  // Decode of one postbyte. Results hold between strobes, so the address
  // adder can keep using them while the offset bytes are still fetched.
  always_comb begin
    valid_d = postbyte_valid_i;
    base_d  = base_q;
    kind_d  = kind_q;
    step_d  = step_q;
    ind_d   = ind_q;
    abs_d   = abs_q;
    bytes_d = bytes_q;
    cyc_d   = cyc_q;
    off_d   = off_q;
    ill_d   = ill_q;
    if (postbyte_valid_i) begin
      base_d  = base_of(postbyte_i[PB_SEL_HI:PB_SEL_LO]);
      kind_d  = IPD_OFF_NONE;
      step_d  = IPD_STEP_NONE;
      ind_d   = 1'b0;
      abs_d   = 1'b0;
      bytes_d = BYTES_NONE;
      cyc_d   = CYC_NONE;
      off_d   = '0;
      ill_d   = 1'b0;
      if (!postbyte_i[PB_MODE_BIT]) begin
        // Bit 4 is the offset sign here, so this form can never be indirect;
        // an indirect short offset is built by the assembler as the 8-bit form.
        kind_d = IPD_OFF_FIVE;
        cyc_d  = CYC_OFF5;
        off_d  = sext5(postbyte_i[PB_OFF5_HI:0]);
      end else begin
        ind_d = ind_bit;
        case (low_nib)
          LN_INC1: begin
            step_d = IPD_STEP_INC1;
            cyc_d  = CYC_STEP1;
            ill_d  = ind_bit;
          end
          LN_INC2: begin
            step_d = IPD_STEP_INC2;
            cyc_d  = CYC_STEP2;
          end
          LN_DEC1: begin
            step_d = IPD_STEP_DEC1;
            cyc_d  = CYC_STEP1;
            ill_d  = ind_bit;
          end
          LN_DEC2: begin
            step_d = IPD_STEP_DEC2;
            cyc_d  = CYC_STEP2;
          end
          LN_ZERO: begin
            kind_d = IPD_OFF_NONE;
            cyc_d  = CYC_ZERO;
          end
          LN_ACC_LOW: begin
            kind_d = IPD_OFF_ACC_LOW;
            cyc_d  = CYC_ACC8;
          end
          LN_ACC_HIGH: begin
            kind_d = IPD_OFF_ACC_HIGH;
            cyc_d  = CYC_ACC8;
          end
          LN_ACC_PAIR: begin
            kind_d = IPD_OFF_ACC_PAIR;
            cyc_d  = CYC_PAIR;
          end
          LN_OFF8: begin
            kind_d  = IPD_OFF_EIGHT;
            cyc_d   = CYC_OFF8;
            bytes_d = BYTES_ONE;
          end
          LN_OFF16: begin
            kind_d  = IPD_OFF_SIXTEEN;
            cyc_d   = CYC_OFF16;
            bytes_d = BYTES_TWO;
          end
          LN_PCREL8: begin
            base_d  = IPD_BASE_PROG_CNT;
            kind_d  = IPD_OFF_EIGHT;
            cyc_d   = CYC_PCR8;
            bytes_d = BYTES_ONE;
          end
          LN_PCREL16: begin
            base_d  = IPD_BASE_PROG_CNT;
            kind_d  = IPD_OFF_SIXTEEN;
            cyc_d   = CYC_PCR16;
            bytes_d = BYTES_TWO;
          end
          LN_ABS: begin
            // Only one exact byte is defined; the other selects are holes.
            if (postbyte_i == ABS_POSTBYTE) begin
              abs_d   = 1'b1;
              base_d  = IPD_BASE_NONE;
              kind_d  = IPD_OFF_ABSOLUTE;
              cyc_d   = CYC_ABS;
              bytes_d = BYTES_TWO;
            end else begin
              ill_d = 1'b1;
            end
          end
          default: ill_d = 1'b1;
        endcase
        // The absolute form already carries its full cost.
        if (ind_bit && !abs_d) begin
          cyc_d = cyc_d + IND_EXTRA;
        end
      end
      // An undefined form must not steer the adder, so its fields are blanked.
      if (ill_d) begin
        base_d  = IPD_BASE_NONE;
        kind_d  = IPD_OFF_NONE;
        step_d  = IPD_STEP_NONE;
        ind_d   = 1'b0;
        abs_d   = 1'b0;
        bytes_d = BYTES_NONE;
        cyc_d   = CYC_NONE;
        off_d   = '0;
      end
    end
  end

  // Decode registers; the result is ready one cycle after the strobe.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      base_q  <= IPD_BASE_NONE;
      kind_q  <= IPD_OFF_NONE;
      step_q  <= IPD_STEP_NONE;
      ind_q   <= 1'b0;
      abs_q   <= 1'b0;
      bytes_q <= BYTES_NONE;
      cyc_q   <= CYC_NONE;
      off_q   <= '0;
      ill_q   <= 1'b0;
    end else begin
      valid_q <= valid_d;
      base_q  <= base_d;
      kind_q  <= kind_d;
      step_q  <= step_d;
      ind_q   <= ind_d;
      abs_q   <= abs_d;
      bytes_q <= bytes_d;
      cyc_q   <= cyc_d;
      off_q   <= off_d;
      ill_q   <= ill_d;
    end
  end

  assign dec_valid_o    = valid_q;
  assign base_o         = base_q;
  assign offset_kind_o  = kind_q;
  assign step_o         = step_q;
  assign indirect_o     = ind_q;
  assign abs_indirect_o = abs_q;
  assign extra_bytes_o  = bytes_q;
  assign extra_cycles_o = cyc_q;
  assign short_offset_o = off_q;
  assign illegal_o      = ill_q;

  // Transfer and exchange register field decode.
  ipd_xfer_decode u_xfer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .code_i    (xfer_code_i),
    .valid_i   (xfer_valid_i),
    .valid_o   (xfer_valid_o),
    .reg_o     (xfer_reg_o),
    .wide_o    (xfer_wide_o),
    .illegal_o (xfer_illegal_o)
  );

  // Checks tie each decoded output to the byte strobed one cycle before.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_short;
    postbyte_valid_i && !postbyte_i[7] |=> dec_valid_o && offset_kind_o == IPD_OFF_FIVE
      && extra_cycles_o == 4'h1 && extra_bytes_o == 2'h0 && !indirect_o
      && short_offset_o == {{11{$past(postbyte_i[4])}}, $past(postbyte_i[4:0])};
  endproperty
  a_short: assert property (p_short) else $error("short offset misdecoded");

  property p_base;
    postbyte_valid_i && !postbyte_i[7] && postbyte_i[6:5] == 2'h3
      |=> base_o == IPD_BASE_CALL_FRAME;
  endproperty
  a_base: assert property (p_base) else $error("base select misdecoded");

  property p_zero;
    postbyte_valid_i && postbyte_i[7] && postbyte_i[3:0] == 4'h4
      |=> offset_kind_o == IPD_OFF_NONE && extra_bytes_o == 2'h0
      && extra_cycles_o == ($past(postbyte_i[4]) ? 4'h3 : 4'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero offset cost wrong");

  property p_off8;
    postbyte_valid_i && postbyte_i[7] && postbyte_i[3:0] == 4'h8
      |=> offset_kind_o == IPD_OFF_EIGHT && extra_bytes_o == 2'h1
      && indirect_o == $past(postbyte_i[4])
      && extra_cycles_o == ($past(postbyte_i[4]) ? 4'h4 : 4'h1);
  endproperty
  a_off8: assert property (p_off8) else $error("8-bit offset misdecoded");

  property p_off16;
    postbyte_valid_i && postbyte_i == 8'hB9 |=> offset_kind_o == IPD_OFF_SIXTEEN
      && base_o == IPD_BASE_INDEX_TWO && indirect_o && extra_bytes_o == 2'h2
      && extra_cycles_o == 4'h7;
  endproperty
  a_off16: assert property (p_off16) else $error("16-bit offset misdecoded");

  property p_pair;
    postbyte_valid_i && postbyte_i[7] && postbyte_i[3:0] == 4'hB
      |=> offset_kind_o == IPD_OFF_ACC_PAIR && extra_bytes_o == 2'h0
      && extra_cycles_o == ($past(postbyte_i[4]) ? 4'h7 : 4'h4);
  endproperty
  a_pair: assert property (p_pair) else $error("pair offset cost wrong");

  property p_step;
    postbyte_valid_i && postbyte_i[7] && postbyte_i[4:0] == 5'h02
      |=> step_o == IPD_STEP_DEC1 && extra_cycles_o == 4'h2 && !illegal_o;
  endproperty
  a_step: assert property (p_step) else $error("single step misdecoded");

  property p_step_ind;
    postbyte_valid_i && postbyte_i[7] && postbyte_i[4] && postbyte_i[3:1] == 3'h0
      |=> (illegal_o != $past(postbyte_i[0])) && (illegal_o || extra_cycles_o == 4'h6);
  endproperty
  a_step_ind: assert property (p_step_ind) else $error("step indirection wrong");

  property p_pcrel;
    postbyte_valid_i && postbyte_i[7] && postbyte_i[3:0] == 4'hD
      |=> base_o == IPD_BASE_PROG_CNT && extra_bytes_o == 2'h2
      && extra_cycles_o == ($past(postbyte_i[4]) ? 4'h8 : 4'h5);
  endproperty
  a_pcrel: assert property (p_pcrel) else $error("relative form misdecoded");

  property p_abs;
    postbyte_valid_i && postbyte_i == 8'h9F |=> abs_indirect_o && indirect_o
      && extra_cycles_o == 4'h5 && extra_bytes_o == 2'h2 && !illegal_o;
  endproperty
  a_abs: assert property (p_abs) else $error("absolute indirect wrong");

  property p_hole;
    postbyte_valid_i && postbyte_i[7] && postbyte_i[3:0] == 4'h7
      |=> illegal_o && base_o == IPD_BASE_NONE && extra_cycles_o == 4'h0
      ##1 dec_valid_o || illegal_o;
  endproperty
  a_hole: assert property (p_hole) else $error("undefined code not flagged");

  c_short: cover property (postbyte_valid_i ##1 offset_kind_o == IPD_OFF_FIVE);
  c_abs:   cover property (postbyte_valid_i ##1 abs_indirect_o);
  c_ill:   cover property (postbyte_valid_i ##1 illegal_o ##1 dec_valid_o && !illegal_o);

endmodule : ipd_decoder

// *** verification/ipd_fetch_model.sv ***
// Stand-in for the fetch sequencer that feeds postbytes and transfer fields.
// Assumes the bench posts a plan at any time; the plan is launched on the falling edge.
`timescale 1ns/1ps
module ipd_fetch_model (
  input  wire logic       clk_i,       // Processor clock.
  input  wire logic       rst_i,       // Asynchronous reset, active high.
  input  wire logic [7:0] plan_pb_i,   // Next postbyte to present.
  input  wire logic       plan_pv_i,   // Present a postbyte strobe.
  input  wire logic [3:0] plan_xc_i,   // Next transfer field to present.
  input  wire logic       plan_xv_i,   // Present a transfer strobe.
  output logic      [7:0] pb_o,        // Postbyte to the decoder.
  output logic            pv_o,        // Postbyte strobe.
  output logic      [3:0] xc_o,        // Transfer field to the decoder.
  output logic            xv_o         // Transfer strobe.
);
  // Idle data lines flip every cycle, so a decoder that samples without a strobe
  // shows it instead of quietly reusing the last byte.
  always_ff @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pb_o <= 8'h00;
      pv_o <= 1'b0;
      xc_o <= 4'h0;
      xv_o <= 1'b0;
    end else begin
      pb_o <= plan_pv_i ? plan_pb_i : ~pb_o;
      pv_o <= plan_pv_i;
      xc_o <= plan_xv_i ? plan_xc_i : ~xc_o;
      xv_o <= plan_xv_i;
    end
  end
endmodule : ipd_fetch_model

// *** verification/test_indexed_postbyte_decoder.sv ***
// Self-checking bench for the indexed postbyte decoder.
// Assumes the fetch model drives the decoder; expectations come from bench functions.
`timescale 1ns/1ps
module test_indexed_postbyte_decoder;
  import ipd_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic [7:0] plan_pb = 8'h00, pb;
  logic plan_pv = 1'b0, plan_xv = 1'b0, pv, xv;
  logic [3:0] plan_xc = 4'h0, xc;
  logic dv, ind, abs_ind, ill, xfv, xwide, xill;
  ipd_base_t base; ipd_offset_t offk; ipd_step_t step; ipd_reg_t xreg;
  logic [1:0] nbytes; logic [3:0] ncyc; logic [15:0] soff;
  logic [33:0] e_dec = '0;
  logic [5:0] e_xf = '0;
  int n_fail = 0, checked = 0, seed = 12, i;
  logic [31:0] r;

  // The clock runs at 100 MHz.
  always #5 clk_i = ~clk_i;

  ipd_fetch_model u_seq (.clk_i(clk_i), .rst_i(rst_i), .plan_pb_i(plan_pb), .plan_pv_i(plan_pv),
    .plan_xc_i(plan_xc), .plan_xv_i(plan_xv), .pb_o(pb), .pv_o(pv), .xc_o(xc), .xv_o(xv));

  ipd_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .postbyte_i(pb), .postbyte_valid_i(pv),
    .xfer_code_i(xc), .xfer_valid_i(xv), .dec_valid_o(dv), .base_o(base),
    .offset_kind_o(offk), .step_o(step), .indirect_o(ind), .abs_indirect_o(abs_ind),
    .extra_bytes_o(nbytes), .extra_cycles_o(ncyc), .short_offset_o(soff), .illegal_o(ill),
    .xfer_valid_o(xfv), .xfer_reg_o(xreg), .xfer_wide_o(xwide), .xfer_illegal_o(xill));

  // Expected decode fields; an undefined byte leaves only the illegal flag set.
  function automatic logic [33:0] exp_pb(input logic [7:0] p);
    logic [2:0] b, o, s;
    logic       in, ab, il;
    logic [1:0] nb;
    logic [3:0] cy;
    logic [15:0] so;
    b = 3'(p[6:5]) + 3'h1;
    o = IPD_OFF_NONE; s = IPD_STEP_NONE; in = p[7] & p[4];
    ab = 1'b0; il = 1'b0; nb = 2'h0; cy = 4'h0; so = 16'h0000;
    if (!p[7]) begin
      o = IPD_OFF_FIVE; cy = 4'h1; so = {{11{p[4]}}, p[4:0]};
    end else case (p[3:0])
      4'h0: begin s = IPD_STEP_INC1; cy = 4'h2; il = p[4]; end
      4'h1: begin s = IPD_STEP_INC2; cy = 4'h3; end
      4'h2: begin s = IPD_STEP_DEC1; cy = 4'h2; il = p[4]; end
      4'h3: begin s = IPD_STEP_DEC2; cy = 4'h3; end
      4'h4: ;
      4'h5: begin o = IPD_OFF_ACC_LOW; cy = 4'h1; end
      4'h6: begin o = IPD_OFF_ACC_HIGH; cy = 4'h1; end
      4'h8: begin o = IPD_OFF_EIGHT; cy = 4'h1; nb = 2'h1; end
      4'h9: begin o = IPD_OFF_SIXTEEN; cy = 4'h4; nb = 2'h2; end
      4'hB: begin o = IPD_OFF_ACC_PAIR; cy = 4'h4; end
      4'hC: begin b = IPD_BASE_PROG_CNT; o = IPD_OFF_EIGHT; cy = 4'h1; nb = 2'h1; end
      4'hD: begin b = IPD_BASE_PROG_CNT; o = IPD_OFF_SIXTEEN; cy = 4'h5; nb = 2'h2; end
      // The absolute form is always indirect; 2 plus the indirect 3 gives its 5 cycles.
      4'hF: begin
        if (p == 8'h9F) begin
          b = IPD_BASE_NONE; o = IPD_OFF_ABSOLUTE; ab = 1'b1; nb = 2'h2; cy = 4'h2;
        end else il = 1'b1;
      end
      default: il = 1'b1;
    endcase
    if (in) cy = cy + 4'h3;
    if (il) return {17'h00000, 1'b1, 16'h0000};
    return {b, o, s, in, ab, nb, cy, il, so};
  endfunction : exp_pb

  // Expected transfer decode: register, wide flag, illegal flag.
  function automatic logic [5:0] exp_xf(input logic [3:0] c);
    if (c <= 4'h5) return {c + 4'h1, 1'b1, 1'b0};
    if (c >= 4'h8 && c <= 4'hB) return {c - 4'h1, 1'b0, 1'b0};
    return {4'h0, 1'b0, 1'b1};
  endfunction : exp_xf

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Compares every decoder output against the held expectation.
  task automatic cmp_all(input logic pv_e, input logic xv_e);
    check("postbyte decode", 48'({dv, base, offk, step, ind, abs_ind, nbytes, ncyc, ill, soff}),
          48'({pv_e, e_dec}));
    check("transfer decode", 48'({xfv, xreg, xwide, xill}), 48'({xv_e, e_xf}));
  endtask : cmp_all

  // Plans one cycle of traffic and checks the answer just after the taking edge.
  task automatic cyc(input logic [7:0] p, input logic v, input logic [3:0] c, input logic w);
    plan_pb = p; plan_pv = v; plan_xc = c; plan_xv = w;
    @(negedge clk_i);
    @(posedge clk_i);
    #1;
    if (v) e_dec = exp_pb(p);
    if (w) e_xf = exp_xf(c);
    cmp_all(v, w);
  endtask : cyc

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // A hang is cut short well beyond the roughly 580 cycles the run needs.
  initial begin
    #50000;
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    // The first edge after release must still show the reset values; waiting for it
    // also keeps the first plan clear of the falling edge that released reset.
    @(posedge clk_i);
    #1;
    cmp_all(1'b0, 1'b0);
    // Every postbyte and transfer code back to back, strobes high every cycle.
    for (i = 0; i < 256; i++) begin
      cyc(8'(i), 1'b1, 4'(i), 1'b1);
    end
    // Boundary bytes followed by idle cycles in which the fields must hold.
    cyc(8'h10, 1'b1, 4'h5, 1'b1);
    cyc(8'h00, 1'b0, 4'h0, 1'b0);
    cyc(8'h9F, 1'b1, 4'h6, 1'b1);
    cyc(8'hDF, 1'b1, 4'hB, 1'b1);
    cyc(8'h90, 1'b1, 4'h0, 1'b0);
    cyc(8'hFD, 1'b1, 4'h0, 1'b0);
    cyc(8'h00, 1'b0, 4'h0, 1'b0);
    // Random traffic with random gaps between strobes.
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      cyc(r[7:0], r[16], r[11:8], r[17]);
    end
    // A reset in mid-run must blank every output at once and after release.
    @(negedge clk_i);
    rst_i = 1'b1;
    plan_pv = 1'b0;
    plan_xv = 1'b0;
    e_dec = '0;
    e_xf = '0;
    #1;
    cmp_all(1'b0, 1'b0);
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    @(posedge clk_i);
    #1;
    cmp_all(1'b0, 1'b0);
    cyc(8'h00, 1'b0, 4'h0, 1'b0);
    cyc(8'h89, 1'b1, 4'hA, 1'b1);
    give_verdict();
  end
endmodule : test_indexed_postbyte_decoder
